// file: rtl/rxcc_pkg.sv
// Shared constants, types and register map of the receive clock-correction block
package rxcc_pkg;

  // ==========================================================================
  // Data carrier
  localparam int SYM_W   = 10;
  localparam int REG_W   = 32;
  localparam int CNT_W   = 8;
  localparam int SEQ_MAX = 4;

  typedef struct packed {
    logic             disp;  // Running disparity of this symbol
    logic [SYM_W-1:0] sym;   // Received 10-bit symbol
  } rxcc_word_t;

  // ==========================================================================
  // Register word indices (byte offset is four times the index)
  localparam logic [3:0] IDX_CTRL    = 4'h0;
  localparam logic [3:0] IDX_LAT     = 4'h1;
  localparam logic [3:0] IDX_GAP     = 4'h2;
  localparam logic [3:0] IDX_LEN     = 4'h3;
  localparam logic [3:0] IDX_MASK    = 4'h4;
  localparam logic [3:0] IDX_SEQ1_LO = 4'h5;
  localparam logic [3:0] IDX_SEQ1_HI = 4'h6;
  localparam logic [3:0] IDX_SEQ2_LO = 4'h7;
  localparam logic [3:0] IDX_SEQ2_HI = 4'h8;
  localparam logic [3:0] IDX_STATUS  = 4'h9;
  localparam int         NUM_CFG     = 9;

  // ==========================================================================
  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_KEEP_BIT = 1;
  localparam int CTRL_PRIO_BIT = 2;
  localparam int CTRL_SEQ2_BIT = 3;
  localparam int CTRL_FLAG_BIT = 4;
  localparam int LAT_LO_POS    = 0;
  localparam int LAT_HI_POS    = 8;
  localparam int LEN_MATCH_POS = 0;
  localparam int LEN_ADJ_POS   = 4;
  localparam int MASK_W        = 4;
  localparam int SEQ_HI_POS    = 16;
  localparam int STAT_OCC_POS  = 0;
  localparam int STAT_SKIP_POS = 8;
  localparam int STAT_REP_POS  = 16;
  localparam int STAT_OVF_BIT  = 24;

  // ==========================================================================
  // Reset values and writable bits
  localparam logic [REG_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [REG_W-1:0] LAT_RST  = 32'h0000_0C04;
  localparam logic [REG_W-1:0] GAP_RST  = 32'h0000_0010;
  localparam logic [REG_W-1:0] LEN_RST  = 32'h0000_0011;
  localparam logic [REG_W-1:0] MASK_RST = 32'h0000_00FF;
  localparam logic [REG_W-1:0] SEQ_RST  = 32'h0000_0000;
  localparam logic [REG_W-1:0] CTRL_WM  = 32'h0000_001F;
  localparam logic [REG_W-1:0] LAT_WM   = 32'h0000_FFFF;
  localparam logic [REG_W-1:0] BYTE_WM  = 32'h0000_00FF;
  localparam logic [REG_W-1:0] LEN_WM   = 32'h0000_0077;
  localparam logic [REG_W-1:0] SEQ_WM   = 32'h03FF_03FF;

  function automatic logic [REG_W-1:0] cfg_rst_val(input logic [3:0] idx);
    unique case (idx)
      IDX_CTRL: cfg_rst_val = CTRL_RST;
      IDX_LAT:  cfg_rst_val = LAT_RST;
      IDX_GAP:  cfg_rst_val = GAP_RST;
      IDX_LEN:  cfg_rst_val = LEN_RST;
      IDX_MASK: cfg_rst_val = MASK_RST;
      default:  cfg_rst_val = SEQ_RST;
    endcase
  endfunction : cfg_rst_val

  function automatic logic [REG_W-1:0] cfg_wmask(input logic [3:0] idx);
    unique case (idx)
      IDX_CTRL:         cfg_wmask = CTRL_WM;
      IDX_LAT:          cfg_wmask = LAT_WM;
      IDX_GAP, IDX_MASK: cfg_wmask = BYTE_WM;
      IDX_LEN:          cfg_wmask = LEN_WM;
      default:          cfg_wmask = SEQ_WM;
    endcase
  endfunction : cfg_wmask

  // ==========================================================================
  // Read-side sequencer states
  typedef enum logic [2:0] {
    ST_SCAN   = 3'b001,
    ST_THRU   = 3'b010,
    ST_REPEAT = 3'b100
  } rxcc_state_t;

endpackage : rxcc_pkg

// file: rtl/rxcc_elastic_corr.sv
// Receive elastic buffer with clock correction, bonding arbitration and register slave
// ============================================================================
// What this block does
// - Correct only while correction is enabled
// - Keep option never removes the last sequence
// - Above upper bound, skip to lower occupancy
// - Below lower bound, repeat to raise occupancy
// - Priority setting orders correction against bonding
// - Hold off configured cycles between corrections
// - Two sequences of four 10-bit entries
// - Per-entry mask bit enables the compare; a cleared bit makes the entry don't-care
// - Second sequence searched only when active
// - Match length and adjust length are configurable
// - Disparity output may flag inserted symbols
`timescale 1ns/10ps
`default_nettype none

module rxcc_elastic_corr #(
  parameter int DEPTH_W = 4                        // Buffer holds 2**DEPTH_W symbols
) (
  input  wire logic                      clk_i,             // User receive clock, 125 MHz
  input  wire logic                      sys_rst_i,         // Synchronous reset, active high
  input  wire logic                      ce_i,              // Clock enable for clk_i state
  input  wire logic [5:0]                avs_address_i,     // Byte address
  input  wire logic                      avs_read_i,        // Read request
  input  wire logic                      avs_write_i,       // Write request
  input  wire logic [31:0]               avs_writedata_i,   // Write data
  input  wire logic [3:0]                avs_byteenable_i,  // Byte lanes
  output logic      [31:0]               avs_readdata_o,    // Read data
  output logic                           avs_waitrequest_o, // Stall
  input  wire logic                      rec_clk_i,         // Recovered link clock
  input  wire rxcc_pkg::rxcc_word_t      link_word_i,       // Symbol from the link side
  input  wire logic                      link_valid_i,      // Symbol valid on rec_clk_i
  input  wire logic                      bond_req_i,        // Bonding trigger from fabric
  output logic                           bond_go_o,         // Bonding granted, one pulse
  output logic      [rxcc_pkg::SYM_W-1:0] rx_data_o,        // Symbol delivered to user
  output logic                           rx_valid_o,        // rx_data_o holds a symbol
  output logic                           rx_disparity_status_o // Disparity or inserted flag
);

  localparam int PW = DEPTH_W + 1;

  // ==========================================================================
  // Gray helpers and length clamp
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int k = PW - 2; k >= 0; k--)
    begin
      b[k] = b[k+1] ^ g[k];
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic [2:0] len_clamp(input logic [2:0] v);
    if (v == 3'h0)
      len_clamp = 3'h1;
    else if (v > 3'h4)
      len_clamp = 3'h4;
    else
      len_clamp = v;
  endfunction : len_clamp

  // ==========================================================================
  // Declarations
  rxcc_pkg::rxcc_word_t        mem [2**DEPTH_W];
  logic                        rst_meta_reg;
  logic                        rst_link_reg;
  logic [PW-1:0]               wr_bin_reg;
  logic [PW-1:0]               wr_gray_reg;
  logic [PW-1:0]               rdg_meta_reg;
  logic [PW-1:0]               rdg_sync_reg;
  logic                        ovf_tgl_reg;
  logic                        buf_full;
  logic [PW-1:0]               wrg_meta_reg;
  logic [PW-1:0]               wrg_sync_reg;
  logic [2:0]                  ovf_sync_reg;
  logic [PW-1:0]               rd_ptr_reg;
  logic [PW-1:0]               rd_ptr_next;
  logic [PW-1:0]               rd_chase_reg;
  logic [PW-1:0]               rd_gray_reg;
  logic [PW-1:0]               occ;
  logic [rxcc_pkg::CNT_W-1:0]  occ_w;
  rxcc_pkg::rxcc_state_t       state_reg;
  rxcc_pkg::rxcc_state_t       state_next;
  logic [2:0]                  cnt_reg;
  logic [2:0]                  cnt_next;
  logic                        prev_seq_reg;
  logic                        prev_seq_next;
  rxcc_pkg::rxcc_word_t        out_word_next;
  logic                        out_vld_next;
  logic                        out_ins_next;
  logic [rxcc_pkg::REG_W-1:0]  cfg_reg [rxcc_pkg::NUM_CFG];
  logic [rxcc_pkg::SYM_W-1:0]  seq_val [2][rxcc_pkg::SEQ_MAX];
  logic [rxcc_pkg::REG_W-1:0]  sw;
  logic [1:0]                  seq_hit;
  logic                        hit;
  logic [2:0]                  det_n;
  logic [2:0]                  adj_n;
  logic                        corr_en;
  logic                        keep_one_sequence;
  logic                        corr_over_bonding_priority;
  logic                        seq2_active;
  logic                        inserted_flag_select;
  logic [rxcc_pkg::CNT_W-1:0]  latency_lower_bound;
  logic [rxcc_pkg::CNT_W-1:0]  latency_upper_bound;
  logic [rxcc_pkg::CNT_W-1:0]  corr_gap_cycles;
  logic [rxcc_pkg::CNT_W-1:0]  gap_cnt_reg;
  logic                        want_skip;
  logic                        want_rep;
  logic                        corr_want;
  logic                        corr_skip;
  logic                        corr_rep;
  logic                        bond_pend_reg;
  logic [rxcc_pkg::CNT_W-1:0]  skip_cnt_reg;
  logic [rxcc_pkg::CNT_W-1:0]  rep_cnt_reg;
  logic                        ovf_flag_reg;
  logic                        ovf_event;
  logic                        ack_reg;
  logic [3:0]                  reg_idx;
  logic [rxcc_pkg::REG_W-1:0]  be_mask;
  logic [rxcc_pkg::REG_W-1:0]  status_word;
  logic [rxcc_pkg::REG_W-1:0]  rd_mux;
  logic                        wr_hit;

  // ==========================================================================
  // Link domain: reset crossing and buffer write side
  always_ff @(posedge rec_clk_i)
  begin
    rst_meta_reg <= sys_rst_i;
    rst_link_reg <= rst_meta_reg;
  end

  always_ff @(posedge rec_clk_i)
  begin
    if (rst_link_reg)
    begin
      rdg_meta_reg <= '0;
      rdg_sync_reg <= '0;
    end
    else
    begin
      rdg_meta_reg <= rd_gray_reg;
      rdg_sync_reg <= rdg_meta_reg;
    end
  end

  // Full uses a lagging copy of the read pointer, so it can only err on the safe side
  assign buf_full = (wr_gray_reg == {~rdg_sync_reg[PW-1:PW-2], rdg_sync_reg[PW-3:0]});

  always_ff @(posedge rec_clk_i)
  begin
    if (rst_link_reg)
    begin
      wr_bin_reg  <= '0;
      wr_gray_reg <= '0;
      ovf_tgl_reg <= 1'b0;
    end
    else if (link_valid_i)
    begin
      if (buf_full)
        ovf_tgl_reg <= ~ovf_tgl_reg;
      else
      begin
        wr_bin_reg  <= wr_bin_reg + PW'(1);
        wr_gray_reg <= bin2gray(wr_bin_reg + PW'(1));
      end
    end
  end

  always_ff @(posedge rec_clk_i)
  begin
    if (link_valid_i && !buf_full)
      mem[wr_bin_reg[DEPTH_W-1:0]] <= link_word_i;
  end

  // ==========================================================================
  // Crossings into clk_i
  // Overflow travels as a toggle: an even number of drops while ce_i is low cancels out
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wrg_meta_reg <= '0;
      wrg_sync_reg <= '0;
      ovf_sync_reg <= 3'h0;
    end
    else if (ce_i)
    begin
      wrg_meta_reg <= wr_gray_reg;
      wrg_sync_reg <= wrg_meta_reg;
      ovf_sync_reg <= {ovf_sync_reg[1:0], ovf_tgl_reg};
    end
  end

  assign ovf_event = ovf_sync_reg[2] ^ ovf_sync_reg[1];
  assign occ       = gray2bin(wrg_sync_reg) - rd_ptr_reg;
  assign occ_w     = rxcc_pkg::CNT_W'(occ);

  // Read pointer leaves for the link side one step at a time, so its gray code never jumps
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_chase_reg <= '0;
      rd_gray_reg  <= '0;
    end
    else if (ce_i && rd_chase_reg != rd_ptr_reg)
    begin
      rd_chase_reg <= rd_chase_reg + PW'(1);
      rd_gray_reg  <= bin2gray(rd_chase_reg + PW'(1));
    end
  end

  // ==========================================================================
  // Configuration fields
  assign corr_en                    = cfg_reg[rxcc_pkg::IDX_CTRL][rxcc_pkg::CTRL_EN_BIT];
  assign keep_one_sequence          = cfg_reg[rxcc_pkg::IDX_CTRL][rxcc_pkg::CTRL_KEEP_BIT];
  assign corr_over_bonding_priority = cfg_reg[rxcc_pkg::IDX_CTRL][rxcc_pkg::CTRL_PRIO_BIT];
  assign seq2_active                = cfg_reg[rxcc_pkg::IDX_CTRL][rxcc_pkg::CTRL_SEQ2_BIT];
  assign inserted_flag_select       = cfg_reg[rxcc_pkg::IDX_CTRL][rxcc_pkg::CTRL_FLAG_BIT];
  assign latency_lower_bound = cfg_reg[rxcc_pkg::IDX_LAT][rxcc_pkg::LAT_LO_POS +: rxcc_pkg::CNT_W];
  assign latency_upper_bound = cfg_reg[rxcc_pkg::IDX_LAT][rxcc_pkg::LAT_HI_POS +: rxcc_pkg::CNT_W];
  assign corr_gap_cycles     = cfg_reg[rxcc_pkg::IDX_GAP][rxcc_pkg::CNT_W-1:0];
  assign det_n = len_clamp(cfg_reg[rxcc_pkg::IDX_LEN][rxcc_pkg::LEN_MATCH_POS +: 3]);
  assign adj_n = len_clamp(cfg_reg[rxcc_pkg::IDX_LEN][rxcc_pkg::LEN_ADJ_POS +: 3]);

  // ==========================================================================
  // Sequence detection at the read pointer
  always_comb
  begin
    sw      = '0;
    seq_hit = 2'b11;
    for (int s = 0; s < 2; s++)
    begin
      for (int i = 0; i < rxcc_pkg::SEQ_MAX; i++)
      begin
        sw = cfg_reg[int'(rxcc_pkg::IDX_SEQ1_LO) + 2 * s + i / 2];
        seq_val[s][i] = (i % 2 == 1) ? sw[rxcc_pkg::SEQ_HI_POS +: rxcc_pkg::SYM_W]
                                     : sw[rxcc_pkg::SYM_W-1:0];
        if (cfg_reg[rxcc_pkg::IDX_MASK][s * rxcc_pkg::MASK_W + i] && (i < int'(det_n)) &&
            (mem[rd_ptr_reg[DEPTH_W-1:0] + DEPTH_W'(i)].sym != seq_val[s][i]))
          seq_hit[s] = 1'b0;
      end
    end
  end

  assign hit = (occ_w >= rxcc_pkg::CNT_W'(det_n)) &&
               (seq_hit[0] || (seq2_active && seq_hit[1]));

  assign want_skip = corr_en && hit && (state_reg == rxcc_pkg::ST_SCAN) &&
                     (gap_cnt_reg >= corr_gap_cycles) &&
                     (occ_w > latency_upper_bound) &&
                     (occ_w > rxcc_pkg::CNT_W'(adj_n)) &&
                     (!keep_one_sequence || prev_seq_reg);
  assign want_rep  = corr_en && hit && (state_reg == rxcc_pkg::ST_SCAN) &&
                     (gap_cnt_reg >= corr_gap_cycles) && !want_skip &&
                     (occ_w < latency_lower_bound) &&
                     (occ_w >= rxcc_pkg::CNT_W'(adj_n));
  assign corr_want = want_skip || want_rep;
  // Bonding wins the cycle unless correction has been given precedence
  assign corr_skip = want_skip && !(bond_req_i && !corr_over_bonding_priority);
  assign corr_rep  = want_rep && !(bond_req_i && !corr_over_bonding_priority);

  // ==========================================================================
  // Read sequencer
  always_comb
  begin
    state_next    = state_reg;
    rd_ptr_next   = rd_ptr_reg;
    cnt_next      = cnt_reg;
    prev_seq_next = prev_seq_reg;
    out_vld_next  = 1'b0;
    out_ins_next  = 1'b0;
    out_word_next = mem[rd_ptr_reg[DEPTH_W-1:0]];
    unique case (state_reg)
      rxcc_pkg::ST_SCAN:
      begin
        if (occ != '0)
        begin
          out_vld_next = 1'b1;
          if (corr_skip)
          begin
            // Drop adj_n symbols and hand out the one behind them in the same cycle
            out_word_next = mem[rd_ptr_reg[DEPTH_W-1:0] + DEPTH_W'(adj_n)];
            rd_ptr_next   = rd_ptr_reg + PW'(adj_n) + PW'(1);
          end
          else if (corr_rep)
          begin
            out_ins_next = 1'b1;
            if (adj_n != 3'h1)
            begin
              state_next = rxcc_pkg::ST_REPEAT;
              cnt_next   = 3'h1;
            end
            else
              prev_seq_next = 1'b1;
          end
          else if (hit)
          begin
            rd_ptr_next = rd_ptr_reg + PW'(1);
            if (det_n != 3'h1)
            begin
              state_next = rxcc_pkg::ST_THRU;
              cnt_next   = 3'h1;
            end
            else
              prev_seq_next = 1'b1;
          end
          else
          begin
            rd_ptr_next   = rd_ptr_reg + PW'(1);
            prev_seq_next = 1'b0;
          end
        end
      end
      rxcc_pkg::ST_THRU:
      begin
        if (occ != '0)
        begin
          out_vld_next = 1'b1;
          rd_ptr_next  = rd_ptr_reg + PW'(1);
          cnt_next     = cnt_reg + 3'h1;
          if (cnt_reg + 3'h1 == det_n)
          begin
            state_next    = rxcc_pkg::ST_SCAN;
            prev_seq_next = 1'b1;
          end
        end
      end
      rxcc_pkg::ST_REPEAT:
      begin
        out_vld_next  = 1'b1;
        out_ins_next  = 1'b1;
        out_word_next = mem[rd_ptr_reg[DEPTH_W-1:0] + DEPTH_W'(cnt_reg)];
        cnt_next      = cnt_reg + 3'h1;
        if (cnt_reg + 3'h1 == adj_n)
        begin
          state_next    = rxcc_pkg::ST_SCAN;
          prev_seq_next = 1'b1;
        end
      end
      default:
      begin
        state_next = rxcc_pkg::ST_SCAN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg    <= rxcc_pkg::ST_SCAN;
      rd_ptr_reg   <= '0;
      cnt_reg      <= 3'h0;
      prev_seq_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg    <= state_next;
      rd_ptr_reg   <= rd_ptr_next;
      cnt_reg      <= cnt_next;
      prev_seq_reg <= prev_seq_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_data_o             <= '0;
      rx_valid_o            <= 1'b0;
      rx_disparity_status_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_data_o             <= out_word_next.sym;
      rx_valid_o            <= out_vld_next;
      rx_disparity_status_o <= inserted_flag_select ? out_ins_next : out_word_next.disp;
    end
  end

  // ==========================================================================
  // Spacing between corrections and bonding arbitration
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      gap_cnt_reg <= '0;
    else if (ce_i)
    begin
      if (corr_skip || corr_rep)
        gap_cnt_reg <= '0;
      else if (gap_cnt_reg != '1)
        gap_cnt_reg <= gap_cnt_reg + rxcc_pkg::CNT_W'(1);
    end
  end

  // A bonding request deferred by correction is granted one cycle later
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      bond_go_o     <= 1'b0;
      bond_pend_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      bond_go_o     <= (bond_req_i && !(corr_want && corr_over_bonding_priority)) || bond_pend_reg;
      bond_pend_reg <= bond_req_i && corr_want && corr_over_bonding_priority;
    end
  end

  // ==========================================================================
  // Statistics
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      skip_cnt_reg <= '0;
      rep_cnt_reg  <= '0;
      ovf_flag_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (corr_skip)
        skip_cnt_reg <= skip_cnt_reg + rxcc_pkg::CNT_W'(1);
      if (corr_rep)
        rep_cnt_reg <= rep_cnt_reg + rxcc_pkg::CNT_W'(1);
      // A new overflow beats a clear in the same cycle
      if (ovf_event)
        ovf_flag_reg <= 1'b1;
      else if (wr_hit && reg_idx == rxcc_pkg::IDX_STATUS && be_mask[rxcc_pkg::STAT_OVF_BIT] &&
               avs_writedata_i[rxcc_pkg::STAT_OVF_BIT])
        ovf_flag_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Register slave: every access answers on the second edge with ce_i high
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  assign reg_idx           = avs_address_i[5:2];
  assign wr_hit            = avs_write_i && ack_reg;

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      be_mask[8*b +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[rxcc_pkg::STAT_OCC_POS +: rxcc_pkg::CNT_W]  = occ_w;
    status_word[rxcc_pkg::STAT_SKIP_POS +: rxcc_pkg::CNT_W] = skip_cnt_reg;
    status_word[rxcc_pkg::STAT_REP_POS +: rxcc_pkg::CNT_W]  = rep_cnt_reg;
    status_word[rxcc_pkg::STAT_OVF_BIT]                     = ovf_flag_reg;
    if (reg_idx < 4'(rxcc_pkg::NUM_CFG))
      rd_mux = cfg_reg[reg_idx];
    else if (reg_idx == rxcc_pkg::IDX_STATUS)
      rd_mux = status_word;
    else
      rd_mux = '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= '0;
    end
    else if (ce_i)
    begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
      if (avs_read_i && !ack_reg)
        avs_readdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int k = 0; k < rxcc_pkg::NUM_CFG; k++)
        cfg_reg[k] <= rxcc_pkg::cfg_rst_val(4'(k));
    end
    else if (ce_i && wr_hit && reg_idx < 4'(rxcc_pkg::NUM_CFG))
    begin
      cfg_reg[reg_idx] <= ((cfg_reg[reg_idx] & ~be_mask) | (avs_writedata_i & be_mask)) &
                          rxcc_pkg::cfg_wmask(reg_idx);
    end
  end

endmodule : rxcc_elastic_corr

`default_nettype wire

// file: test/rxcc_props.sv
// Port checker for the clock-correction block
`timescale 1ns/10ps
`default_nettype none
module rxcc_props (
  input wire logic clk_i,              // Clock
  input wire logic sys_rst_i,          // Reset
  input wire logic ce_i,               // Enable
  input wire logic avs_read_i,         // Read
  input wire logic avs_write_i,        // Write
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o,  // Stall
  input wire logic bond_req_i,         // Bond ask
  input wire logic bond_go_o,          // Bond grant
  input wire logic rx_valid_o          // Symbol valid
);
  wire req = avs_read_i | avs_write_i;
  // ==========
  // Bus, bonding and hold checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_IDLE: assert property (!req |-> !avs_waitrequest_o) else $error("stall, no request");
  AST_ACK: assert property (req && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o) else $error("no answer");
  AST_ONE: assert property (req && !avs_waitrequest_o && ce_i |=> avs_waitrequest_o || !req)
    else $error("long ack");
  AST_HOLD: assert property (!(avs_read_i && avs_waitrequest_o && ce_i) |=> $stable(avs_readdata_o))
    else $error("data moved");
  AST_QUIET: assert property ($fell(sys_rst_i) |-> !rx_valid_o && !bond_go_o) else $error("busy at start");
  AST_GRANT: assert property (bond_req_i && ce_i |-> ##[1:2] bond_go_o) else $error("no grant");
  AST_CAUSE: assert property (bond_go_o |-> $past(bond_req_i) || $past(bond_req_i, 2)) else $error("stray");
  AST_FREEZE: assert property (!ce_i |=> $stable(rx_valid_o) && $stable(bond_go_o)) else $error("moved");
endmodule : rxcc_props
bind rxcc_elastic_corr rxcc_props u_props (.clk_i, .sys_rst_i, .ce_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .bond_req_i, .bond_go_o, .rx_valid_o);
`default_nettype wire

// file: test/rxcc_link_src.sv
// Link-side symbol source on the recovered clock
`timescale 1ns/10ps
`default_nettype none
module rxcc_link_src (
  input wire logic rec_clk_i,             // Link clock
  output var rxcc_pkg::rxcc_word_t link_word_o, // Symbol
  output var logic link_valid_o           // Symbol valid
);
  rxcc_pkg::rxcc_word_t q[$];
  initial
  begin
    link_word_o = 11'h000;
    link_valid_o = 1'h0;
  end
  // Idle word toggles so a stale symbol cannot pass for data
  always @(posedge rec_clk_i)
  begin
    link_valid_o <= q.size() > 0;
    link_word_o <= (q.size() > 0) ? q.pop_front() : ~link_word_o;
  end
endmodule : rxcc_link_src
`default_nettype wire

// file: test/tb_top.sv
// Bench for the clock-correction block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [9:0] K = 10'h17C;
  localparam logic [9:0] D = 10'h0A5;
  logic clk_i = 1'h0, rec_clk_i = 1'h0, sys_rst_i = 1'h1, ce_i = 1'h1, bond_req_i = 1'h0;
  logic avs_read_i = 1'h0, avs_write_i = 1'h0, avs_waitrequest_o, link_valid_i, bond_go_o, rx_valid_o;
  logic rx_disparity_status_o;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, st;
  logic [9:0] rx_data_o;
  rxcc_pkg::rxcc_word_t link_word_i;
  int miscompares, n_compared, n_rx, n_k, n_flag, n_go;
  always #4 clk_i = ~clk_i;
  initial #13 forever #40 rec_clk_i = ~rec_clk_i;
  rxcc_elastic_corr u_dut (.clk_i, .sys_rst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .rec_clk_i, .link_word_i, .link_valid_i,
    .bond_req_i, .bond_go_o, .rx_data_o, .rx_valid_o, .rx_disparity_status_o);
  rxcc_link_src u_src (.rec_clk_i, .link_word_o(link_word_i), .link_valid_o(link_valid_i));
  // ==========
  // Delivered symbol counts and bonding grant count
  always @(posedge clk_i)
  begin
    n_go += bond_go_o === 1'h1;
    if (rx_valid_o === 1'h1)
    begin
      n_rx++;
      n_k += rx_data_o === K;
      n_flag += rx_disparity_status_o === 1'h1;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("%0d compared, %0d wrong", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'h0 && ++n < 50);
    st = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    chk(n < 50, 1'h1);
    if (n == 50)
      close_out();
  endtask : bus
  // Holding the read side lets the buffer fill past the upper bound
  task automatic xfer(input int n, input logic hold);
    @(negedge clk_i);
    {n_rx, n_k, n_flag} = '0;
    @(posedge clk_i);
    ce_i <= ~hold;
    for (int i = 0; i < n; i++)
      u_src.q.push_back({i[0], i[0] ? D : K});
    for (int t = 0; t < 3000 && u_src.q.size() > 0; t++)
      @(posedge clk_i);
    ce_i <= 1'h1;
    chk(u_src.q.size(), 32'h0);
    if (u_src.q.size() > 0)
      close_out();
    repeat (40) @(posedge clk_i);
  endtask : xfer
  task automatic s_regs;
    bus(1'h0, 6'h04, 32'h0);
    chk(st, 32'h0000_0C04);
    bus(1'h0, 6'h10, 32'h0);
    chk(st, 32'h0000_00FF);
    bus(1'h1, 6'h14, {22'h0, K});
    bus(1'h0, 6'h14, 32'h0);
    chk(st, {22'h0, K});
    bus(1'h0, 6'h28, 32'h0);
    chk(st, 32'h0);
    bus(1'h1, 6'h10, 32'h1);
    bus(1'h1, 6'h08, 32'h0);
    bus(1'h1, 6'h04, 32'h0C08);
  endtask : s_regs
  task automatic s_pass;
    xfer(8, 1'h0);
    chk(n_rx, 32'h8);
    chk(n_k, 32'h4);
    chk(n_flag, 32'h4);
  endtask : s_pass
  task automatic s_repeat;
    bus(1'h1, 6'h08, 32'h10);
    bus(1'h1, 6'h00, 32'h11);
    xfer(8, 1'h0);
    chk(n_k > 4, 1'h1);
    chk(n_rx - n_k, 32'h4);
    chk(n_flag > 0, 1'h1);
  endtask : s_repeat
  task automatic s_skip;
    bus(1'h1, 6'h04, 32'h0201);
    bus(1'h1, 6'h00, 32'h1);
    // Odd drop count: drops made while frozen cancel in pairs
    xfer(19, 1'h1);
    bus(1'h0, 6'h24, 32'h0);
    chk(st[24], 1'h1);
    chk(st[15:8] != 0, 1'h1);
    bus(1'h1, 6'h24, 32'h0100_0000);
    bus(1'h0, 6'h24, 32'h0);
    chk(st[24], 1'h0);
  endtask : s_skip
  task automatic s_bond;
    for (int p = 0; p < 2; p++)
    begin
      bus(1'h1, 6'h00, {29'h0, p[0], 2'h0});
      bond_req_i <= 1'h1;
      @(posedge clk_i);
      bond_req_i <= 1'h0;
      repeat (4) @(posedge clk_i);
    end
    chk(n_go, 32'h2);
  endtask : s_bond
  initial
  begin
    repeat (6) @(posedge clk_i);
    repeat (3) @(posedge rec_clk_i);
    @(posedge clk_i);
    sys_rst_i <= 1'h0;
    repeat (3) @(posedge rec_clk_i);
    s_regs();
    s_pass();
    s_repeat();
    s_skip();
    s_bond();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
